// *** pkg/sncr_map.svh ***
`ifndef SNCR_MAP_SVH
`define SNCR_MAP_SVH

// register numbers on the configuration access port
`define SNCR_SWITCH_DESCRIPTION 8'h01
`define SNCR_SWITCH_CONFIGURATION 8'h04
`define SNCR_NODE_IDENTIFIER 8'h05
`define SNCR_CLOCK_MULTIPLIER_SETTINGS 8'h06
`define SNCR_SWITCH_CLOCK_DIVIDER 8'h07
`define SNCR_REFERENCE_CLOCK_DIVIDER 8'h08
`define SNCR_JTAG_DEVICE_ID 8'h09
`define SNCR_JTAG_USER_CODE 8'h0a
`define SNCR_DIRECTION_TABLE_LOW 8'h0c
`define SNCR_DIRECTION_TABLE_HIGH 8'h0d
`define SNCR_RESERVED_A 8'h10
`define SNCR_RESERVED_B 8'h11
`define SNCR_DEBUG_EVENT_SOURCE 8'h1f

// switch configuration fields
`define SNCR_CFG_LOCK_BIT 31
`define SNCR_CFG_MULT_LOCK_BIT 8
`define SNCR_CFG_HDR_BIT 0

// clock multiplier settings fields
`define SNCR_MUL_NO_RESET_BIT 31
`define SNCR_MUL_NO_WAIT_BIT 30
`define SNCR_MUL_BYPASS_BIT 29
`define SNCR_MUL_JTAG_BOOT_BIT 28
`define SNCR_MUL_WMASK 32'hf39f_ff7f

// reset values
`define SNCR_REF_DIV_RESET 16'h0003
`define SNCR_MUL_RESET 32'h0000_0000

// tile reset pulse length, in clock cycles
`define SNCR_TILE_RESET_CYCLES 8'h10

`endif

// *** pkg/sncr_pkg.sv ***
package sncr_pkg;

  // configuration access state
  typedef enum logic [1:0] {
    SNCR_IDLE,
    SNCR_RESP
  } sncr_state_e;

  // lookup result
  typedef struct packed {
    logic local_hit;
    logic [3:0] direction;
  } sncr_route_s;

endpackage : sncr_pkg

// *** pkg/sncr_route_if.sv ***
`timescale 1ns/1ps
interface sncr_route_if;
  logic [15:0] node_id;
  logic [31:0] table_low;
  logic [31:0] table_high;
  logic valid;
  logic [15:0] dest_id;
  logic res_valid;
  sncr_pkg::sncr_route_s res;
  modport table_side (output node_id, table_low, table_high, valid, dest_id,
    input res_valid, res);
  modport lookup (input node_id, table_low, table_high, valid, dest_id,
    output res_valid, res);
endinterface : sncr_route_if

// *** hw/sncr_route.sv ***
`timescale 1ns/1ps
module sncr_route (
  input wire logic clk,
  input wire logic rst,
  sncr_route_if.lookup rif
);

  typedef struct packed {
    logic res_valid;
    sncr_pkg::sncr_route_s res;
  } sncr_rst_s;

  sncr_rst_s st;
  sncr_rst_s next_st;

  // index of most significant set bit
  function automatic logic [3:0] sncr_msb(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++)
      if (v[i]) idx = 4'(i);
    return idx;
  endfunction : sncr_msb

  // pick direction by highest mismatching identifier bit
  always_comb
  begin
    logic [15:0] diff;
    logic [3:0] pos;
    logic [63:0] tbl;
    diff = rif.node_id ^ rif.dest_id;
    pos = sncr_msb(diff);
    tbl = {rif.table_high, rif.table_low};
    next_st.res_valid = rif.valid;
    next_st.res.local_hit = (diff == 16'h0000);
    next_st.res.direction = (diff == 16'h0000) ? 4'h0 :
      tbl[{pos, 2'b00} +: 4];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) st <= '0;
    else st <= next_st;
  end

  assign rif.res_valid = st.res_valid;
  assign rif.res = st.res;

endmodule : sncr_route

// *** hw/sncr_regs.sv ***
`timescale 1ns/1ps
`include "sncr_map.svh"
module sncr_regs #(
  parameter int NUM_LINKS = 9,
  parameter logic [7:0] LINK_COUNT = 8'h09,
  parameter logic [7:0] SWITCH_CORES = 8'h02,
  parameter logic [7:0] DEVICE_CORES = 8'h02,
  // arbitrary identity values, not of any part
  parameter logic [31:0] JTAG_ID = 32'h0000_0001,
  parameter logic [13:0] USER_CODE = 14'h0000,
  parameter logic [17:0] FIX_ID = 18'h0_0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic [1:0] halt_src,
  input wire logic halt_event,
  input wire logic [NUM_LINKS*4-1:0] link_direction,
  input wire logic route_valid,
  input wire logic [15:0] route_dest,
  output logic route_done,
  output logic route_local,
  output logic [3:0] route_dir,
  output logic [NUM_LINKS-1:0] route_links,
  output logic one_byte_headers,
  output logic [31:0] clock_multiplier_setup,
  output logic mult_wait_lock,
  output logic mult_bypass,
  output logic jtag_boot,
  output logic [2:0] mult_out_div,
  output logic [12:0] mult_feedback,
  output logic [6:0] mult_in_div,
  output logic [15:0] switch_div,
  output logic [15:0] ref_div,
  output logic tile_reset
);

  // elaboration check: link directions are matched for 1 to 16 links
  if (NUM_LINKS < 1 || NUM_LINKS > 16)
  begin : g_bad_links
    $error("sncr_regs: NUM_LINKS out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    sncr_pkg::sncr_state_e state;
    logic [31:0] rdata;
    logic ack;
    logic lock_all;
    logic lock_mult;
    logic hdr;
    logic [15:0] node_id;
    logic [31:0] mult;
    logic [15:0] sw_div;
    logic [15:0] rf_div;
    logic [31:0] dir_low;
    logic [31:0] dir_high;
    logic [1:0] rsv_a;
    logic [1:0] rsv_b;
    logic [1:0] dbg;
    logic dbg4;
    logic [7:0] trst_cnt;
    logic trst;
    logic done;
    logic loc;
    logic [3:0] dir;
    logic [NUM_LINKS-1:0] links;
  } sncr_regs_s;

  sncr_regs_s st;
  sncr_regs_s next_st;

  sncr_route_if rif ();

  ////////////////////////////////////////////////////////////////////////
  // read mux, reserved bits read zero
  function automatic logic [31:0] sncr_read(input sncr_regs_s s,
    input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      `SNCR_SWITCH_DESCRIPTION:
        d = {8'h00, LINK_COUNT, SWITCH_CORES, DEVICE_CORES};
      `SNCR_SWITCH_CONFIGURATION:
        d = {s.lock_all, 22'h00_0000, s.lock_mult, 7'h00, s.hdr};
      `SNCR_NODE_IDENTIFIER: d = {16'h0000, s.node_id};
      `SNCR_CLOCK_MULTIPLIER_SETTINGS: d = s.mult;
      `SNCR_SWITCH_CLOCK_DIVIDER: d = {16'h0000, s.sw_div};
      `SNCR_REFERENCE_CLOCK_DIVIDER: d = {16'h0000, s.rf_div};
      `SNCR_JTAG_DEVICE_ID: d = JTAG_ID;
      `SNCR_JTAG_USER_CODE: d = {USER_CODE, FIX_ID};
      `SNCR_DIRECTION_TABLE_LOW: d = s.dir_low;
      `SNCR_DIRECTION_TABLE_HIGH: d = s.dir_high;
      `SNCR_RESERVED_A: d = {30'h0000_0000, s.rsv_a};
      `SNCR_RESERVED_B: d = {30'h0000_0000, s.rsv_b};
      `SNCR_DEBUG_EVENT_SOURCE: d = {27'h000_0000, s.dbg4, 2'b00, s.dbg};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : sncr_read

  ////////////////////////////////////////////////////////////////////////
  // register writes, locks, tile reset and routing
  always_comb
  begin
    logic wr_ok;
    wr_ok = cfg_wr && !st.lock_all;
    next_st = st;
    next_st.ack = 1'b0;
    unique case (st.state)
      sncr_pkg::SNCR_IDLE:
      begin
        if (cfg_wr || cfg_rd)
        begin
          next_st.ack = 1'b1;
          next_st.rdata = cfg_rd ? sncr_read(st, cfg_addr) : 32'h0000_0000;
          next_st.state = sncr_pkg::SNCR_RESP;
        end
      end
      sncr_pkg::SNCR_RESP:
      begin
        wr_ok = 1'b0;
        next_st.state = sncr_pkg::SNCR_IDLE;
      end
    endcase
    if (wr_ok)
    begin
      unique case (cfg_addr)
        `SNCR_SWITCH_CONFIGURATION:
        begin
          next_st.lock_all = cfg_wdata[`SNCR_CFG_LOCK_BIT];
          next_st.lock_mult = cfg_wdata[`SNCR_CFG_MULT_LOCK_BIT];
          next_st.hdr = cfg_wdata[`SNCR_CFG_HDR_BIT];
        end
        `SNCR_NODE_IDENTIFIER: next_st.node_id = cfg_wdata[15:0];
        `SNCR_CLOCK_MULTIPLIER_SETTINGS:
        begin
          if (!st.lock_mult)
          begin
            next_st.mult = cfg_wdata & `SNCR_MUL_WMASK;
            if (!cfg_wdata[`SNCR_MUL_NO_RESET_BIT])
            begin
              next_st.trst = 1'b1;
              next_st.trst_cnt = `SNCR_TILE_RESET_CYCLES;
            end
          end
        end
        `SNCR_SWITCH_CLOCK_DIVIDER: next_st.sw_div = cfg_wdata[15:0];
        `SNCR_REFERENCE_CLOCK_DIVIDER:
          next_st.rf_div = cfg_wdata[15:0];
        `SNCR_DIRECTION_TABLE_LOW: next_st.dir_low = cfg_wdata;
        `SNCR_DIRECTION_TABLE_HIGH: next_st.dir_high = cfg_wdata;
        `SNCR_RESERVED_A: next_st.rsv_a = cfg_wdata[1:0];
        `SNCR_RESERVED_B: next_st.rsv_b = cfg_wdata[1:0];
        `SNCR_DEBUG_EVENT_SOURCE:
        begin
          next_st.dbg = cfg_wdata[1:0];
          next_st.dbg4 = cfg_wdata[4];
        end
        default: ;
      endcase
    end
    // a halt event outranks a software write in the same cycle
    if (halt_event)
      next_st.dbg = halt_src;
    // tile reset pulse countdown
    if (st.trst && !(wr_ok && next_st.trst_cnt == `SNCR_TILE_RESET_CYCLES
        && cfg_addr == `SNCR_CLOCK_MULTIPLIER_SETTINGS))
    begin
      next_st.trst_cnt = st.trst_cnt - 8'h01;
      next_st.trst = (st.trst_cnt != 8'h01);
    end
    // register lookup result and match links by direction
    next_st.done = rif.res_valid;
    next_st.loc = rif.res.local_hit;
    next_st.dir = rif.res.direction;
    for (int i = 0; i < NUM_LINKS; i++)
      next_st.links[i] = rif.res_valid && !rif.res.local_hit &&
        (link_direction[i*4 +: 4] == rif.res.direction);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.state <= sncr_pkg::SNCR_IDLE;
      st.rf_div <= `SNCR_REF_DIV_RESET;
      st.mult <= `SNCR_MUL_RESET;
    end
    else st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // lookup engine
  assign rif.node_id = st.node_id;
  assign rif.table_low = st.dir_low;
  assign rif.table_high = st.dir_high;
  assign rif.valid = route_valid;
  assign rif.dest_id = route_dest;

  sncr_route u_route (
    .clk(clk),
    .rst(rst),
    .rif(rif)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign cfg_rdata = st.rdata;
  assign cfg_ack = st.ack;
  assign route_done = st.done;
  assign route_local = st.loc;
  assign route_dir = st.dir;
  assign route_links = st.links;
  assign one_byte_headers = st.hdr;
  assign clock_multiplier_setup = st.mult;
  assign mult_wait_lock = !st.mult[`SNCR_MUL_NO_WAIT_BIT];
  assign mult_bypass = st.mult[`SNCR_MUL_BYPASS_BIT];
  assign jtag_boot = st.mult[`SNCR_MUL_JTAG_BOOT_BIT];
  assign mult_out_div = st.mult[25:23];
  assign mult_feedback = st.mult[20:8];
  assign mult_in_div = st.mult[6:0];
  assign switch_div = st.sw_div;
  assign ref_div = st.rf_div;
  assign tile_reset = st.trst;

  ////////////////////////////////////////////////////////////////////////
  // checks
  lock_blocks_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_wr && !st.ack && st.lock_all &&
     cfg_addr == `SNCR_NODE_IDENTIFIER) |=> $stable(st.node_id))
    else $error("write passed the global lock");
  mult_lock_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_wr && !st.ack && st.lock_mult &&
     cfg_addr == `SNCR_CLOCK_MULTIPLIER_SETTINGS) |=> $stable(st.mult))
    else $error("multiplier write passed its lock");
  tile_reset_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_wr && !st.ack && !st.lock_all && !st.lock_mult &&
     cfg_addr == `SNCR_CLOCK_MULTIPLIER_SETTINGS && !cfg_wdata[31])
    |=> tile_reset [*8])
    else $error("tile reset missing after multiplier write");
  no_reset_a: assert property (@(posedge clk) disable iff (rst)
    (!tile_reset && cfg_wr && !st.ack &&
     cfg_addr == `SNCR_CLOCK_MULTIPLIER_SETTINGS && cfg_wdata[31])
    |=> !tile_reset)
    else $error("tile reset despite suppress bit");
  node_upper_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ack && $past(cfg_rd) && $past(cfg_addr) == `SNCR_NODE_IDENTIFIER
    |-> cfg_rdata[31:16] == 16'h0000)
    else $error("node identifier upper bits nonzero");
  local_hit_a: assert property (@(posedge clk) disable iff (rst)
    route_valid && route_dest == st.node_id && $stable(st.node_id)
    |=> ##1 route_done && route_local && route_links == '0)
    else $error("own identifier not delivered locally");
  halt_src_a: assert property (@(posedge clk) disable iff (rst)
    halt_event |=> st.dbg == $past(halt_src))
    else $error("debug source not recorded");
  ref_reset_a: assert property (@(posedge clk)
    $fell(rst) |-> ref_div == 16'h0003)
    else $error("reference divider reset value wrong");

endmodule : sncr_regs

// *** tb/switch_node_config_regs_tb.sv ***
`timescale 1ns/1ps
`include "sncr_map.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  num_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module switch_node_config_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [1:0] halt_src = 2'h0;
  logic halt_event = 1'b0;
  logic [35:0] link_direction = 36'h8_7654_3210;
  logic route_valid = 1'b0;
  logic [15:0] route_dest = 16'h0000;
  logic [31:0] cfg_rdata, clock_multiplier_setup;
  logic cfg_ack, route_done, route_local, one_byte_headers, mult_wait_lock;
  logic mult_bypass, jtag_boot, tile_reset;
  logic [3:0] route_dir;
  logic [8:0] route_links;
  logic [2:0] mult_out_div;
  logic [12:0] mult_feedback;
  logic [6:0] mult_in_div;
  logic [15:0] switch_div, ref_div;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  // reset values, then all-ones write readback, per address
  logic [7:0] ra [12] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h10, 8'h11};
  logic [31:0] rv [12] = '{32'h0009_0202, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0003, 32'h0000_0001,
    32'ha971_0f3c, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000};
  logic [7:0] wa [12] = '{8'h05, 8'h07, 8'h08, 8'h0c, 8'h0d, 8'h10,
    8'h11, 8'h1f, 8'h01, 8'h09, 8'h0a, 8'h02};
  logic [31:0] wv [12] = '{32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff,
    32'hffff_ffff, 32'hffff_ffff, 32'h0000_0003, 32'h0000_0003,
    32'h0000_0013, 32'h0009_0202, 32'h0000_0001, 32'ha971_0f3c,
    32'h0000_0000};

  // distinct code fields so that their placement in the word is seen
  sncr_regs #(.USER_CODE(14'h2a5c), .FIX_ID(18'h1_0f3c)) dut (.clk(clk),
    .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .halt_src(halt_src), .halt_event(halt_event),
    .link_direction(link_direction), .route_valid(route_valid),
    .route_dest(route_dest), .route_done(route_done),
    .route_local(route_local), .route_dir(route_dir),
    .route_links(route_links), .one_byte_headers(one_byte_headers),
    .clock_multiplier_setup(clock_multiplier_setup),
    .mult_wait_lock(mult_wait_lock), .mult_bypass(mult_bypass),
    .jtag_boot(jtag_boot), .mult_out_div(mult_out_div),
    .mult_feedback(mult_feedback), .mult_in_div(mult_in_div),
    .switch_div(switch_div), .ref_div(ref_div), .tile_reset(tile_reset));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one access: request held one cycle, ack checked in the answer cycle
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cfg_wr <= w;
    cfg_rd <= ~w;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1;
    `CHK(cfg_ack, 1'b1)
    q = cfg_rdata;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask : rd

  // counts answer-cycle-onwards cycles with the tile reset high
  task automatic count_high(output int c);
    c = 0;
    repeat (40)
    begin
      if (tile_reset === 1'b1) c++;
      @(posedge clk);
      #1;
    end
  endtask : count_high

  // one lookup, waiting a bounded time for the result
  task automatic route(input logic [15:0] d, input logic loc,
    input logic [3:0] dr, input logic [8:0] lk);
    int i;
    @(posedge clk);
    route_valid <= 1'b1;
    route_dest <= d;
    @(posedge clk);
    route_valid <= 1'b0;
    i = 0;
    #1;
    while (route_done !== 1'b1 && i < 4)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    `CHK(route_done, 1'b1)
    `CHK(route_local, loc)
    if (!loc) `CHK(route_dir, dr)
    `CHK(route_links, lk)
  endtask : route

  task automatic halt(input logic [1:0] s);
    @(posedge clk);
    halt_src <= s;
    halt_event <= 1'b1;
    @(posedge clk);
    halt_event <= 1'b0;
  endtask : halt

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) rd(ra[i], rv[i]);
    `CHK(ref_div, 16'h0003)
    `CHK(mult_wait_lock, 1'b1)
    for (int i = 0; i < 12; i++)
    begin
      wr(wa[i], 32'hffff_ffff);
      rd(wa[i], wv[i]);
    end
    `CHK(switch_div, 16'hffff)
    wr(`SNCR_CLOCK_MULTIPLIER_SETTINGS, 32'h2e2a_bc95);
    count_high(n);
    `CHK(n, 16)
    rd(`SNCR_CLOCK_MULTIPLIER_SETTINGS, 32'h220a_bc15);
    `CHK(clock_multiplier_setup, 32'h220a_bc15)
    `CHK({mult_out_div, mult_feedback}, {3'h4, 13'h0abc})
    `CHK({mult_in_div, mult_bypass, jtag_boot}, {7'h15, 2'b10})
    wr(`SNCR_CLOCK_MULTIPLIER_SETTINGS, 32'hd000_0001);
    count_high(n);
    `CHK(n, 0)
    `CHK({mult_wait_lock, jtag_boot, mult_bypass}, 3'b010)
    wr(`SNCR_SWITCH_CONFIGURATION, 32'h7fff_ffff);
    rd(`SNCR_SWITCH_CONFIGURATION, 32'h0000_0101);
    `CHK(one_byte_headers, 1'b1)
    wr(`SNCR_CLOCK_MULTIPLIER_SETTINGS, 32'h0000_0000);
    count_high(n);
    `CHK(n, 0)
    rd(`SNCR_CLOCK_MULTIPLIER_SETTINGS, 32'hd000_0001);
    wr(`SNCR_NODE_IDENTIFIER, 32'h0000_1234);
    wr(`SNCR_DIRECTION_TABLE_LOW, 32'h7654_3210);
    wr(`SNCR_DIRECTION_TABLE_HIGH, 32'hfedc_ba98);
    for (int k = 0; k < 16; k++)
      route(16'h1234 ^ (16'hffff >> (15 - k)), 1'b0, 4'(k),
        (k < 9) ? 9'(1 << k) : 9'h000);
    route(16'h1234, 1'b1, 4'h0, 9'h000);
    halt(2'b10);
    rd(`SNCR_DEBUG_EVENT_SOURCE, 32'h0000_0012);
    halt(2'b01);
    rd(`SNCR_DEBUG_EVENT_SOURCE, 32'h0000_0011);
    wr(`SNCR_SWITCH_CONFIGURATION, 32'h8000_0000);
    rd(`SNCR_SWITCH_CONFIGURATION, 32'h8000_0000);
    `CHK(one_byte_headers, 1'b0)
    wr(`SNCR_NODE_IDENTIFIER, 32'h0000_5555);
    rd(`SNCR_NODE_IDENTIFIER, 32'h0000_1234);
    wr(`SNCR_SWITCH_CONFIGURATION, 32'h0000_0000);
    rd(`SNCR_SWITCH_CONFIGURATION, 32'h8000_0000);
    wr(`SNCR_CLOCK_MULTIPLIER_SETTINGS, 32'h0000_0000);
    count_high(n);
    `CHK(n, 0)
    do_reset();
    rd(`SNCR_SWITCH_CONFIGURATION, 32'h0000_0000);
    rd(`SNCR_NODE_IDENTIFIER, 32'h0000_0000);
    end_of_test();
  end
endmodule : switch_node_config_regs_tb
